// file: hdl/quad_dac_readback_decoder.sv
// Register access over APB and the register addresses were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none

// Notes on behaviour
// (RL1) instruction: start bit high, then read bit high selects read mode; seven bits total
// (RL2) global low: last two instruction bits pick channel one to four
// (RL3) fourth bit high: data changes on rising edges, low: on falling edges
// (RL4) fifth bit high: msb first, low: lsb first
// (RL5) global high with select one-zero reads all four channels in succession
// (RL6) supply interruption sets power-fail flag and pulls interrupt pin low
// (RL7) chip select low clears power-fail flag and releases interrupt pin
// (RL8) interrupt pin only pulls low; an external pull-up returns it high
// (RL9) host should distrust channel data whenever it sees the power-fail flag
// (RL10) first change 2 cycles (rising) or 1.5 cycles (falling) after instruction end
// (RL11) global readback returns channel one first, channel four last
// (RL12) serial input ignored until a high start bit arrives
// (RL13) each channel returns its eight latched bits; global returns thirty-two
module quad_dac_readback_decoder
	import quad_readback_pkg::*;
(
	input  wire logic              CLK_I,           // system clock, 50 MHz
	input  wire logic              RST_N_I,         // synchronous reset, active low
	input  wire logic              PSEL_I,          // apb select
	input  wire logic              PENABLE_I,       // apb access phase
	input  wire logic              PWRITE_I,        // apb direction, high = write
	input  wire logic [ADDR_W-1:0] PADDR_I,         // apb byte address
	input  wire logic [DATA_W-1:0] PWDATA_I,        // apb write data
	output logic      [DATA_W-1:0] PRDATA_O,        // apb read data
	output logic                   PREADY_O,        // apb ready
	output logic                   PSLVERR_O,       // apb error, unmapped address
	input  wire logic              CS_N_I,          // chip select pin, active low
	input  wire logic              SCLK_I,          // serial clock pin
	input  wire logic              SERIAL_IN_I,     // serial data in pin
	input  wire logic              SUPPLY_LOST_I,   // supply interruption detector
	output logic                   SERIAL_OUT_O,    // serial readback data
	output logic                   SERIAL_OUT_OE_O, // serial readback drive enable
	input  wire logic              INT_N_I,         // interrupt pin level
	output logic                   INT_N_O,         // interrupt pin drive value
	output logic                   INT_N_OE_O,      // interrupt pin pull-down enable
	output logic                   IRQ_O            // level interrupt to software
);

	////////////////////////////////////////////////////////////////////////////////
	// pin synchronisers

	logic [1:0] cs_sync;
	logic [1:0] sclk_sync;
	logic [1:0] sin_sync;
	logic [1:0] lost_sync;
	logic [1:0] int_sync;
	logic       sclk_d;
	logic       lost_d;

	// reset levels match the pins at rest, so no false edge follows reset
	always_ff @(posedge CLK_I) begin
		if (!RST_N_I) begin
			cs_sync   <= 2'h3;
			sclk_sync <= 2'h0;
			sin_sync  <= 2'h0;
			lost_sync <= 2'h0;
			int_sync  <= 2'h3;
			sclk_d    <= 1'b0;
			lost_d    <= 1'b0;
		end else begin
			cs_sync   <= {cs_sync[0], CS_N_I};
			sclk_sync <= {sclk_sync[0], SCLK_I};
			sin_sync  <= {sin_sync[0], SERIAL_IN_I};
			lost_sync <= {lost_sync[0], SUPPLY_LOST_I};
			int_sync  <= {int_sync[0], INT_N_I};
			sclk_d    <= sclk_sync[1];
			lost_d    <= lost_sync[1];
		end
	end

	wire cs_active = ~cs_sync[1];
	wire sclk_rise = sclk_sync[1] & ~sclk_d;
	wire sclk_fall = ~sclk_sync[1] & sclk_d;
	wire sin_bit   = sin_sync[1];
	wire lost_rise = lost_sync[1] & ~lost_d;

	////////////////////////////////////////////////////////////////////////////////
	// apb decode

	logic [CHAN_BITS-1:0] code [NUM_CHAN];
	logic [IRQ_W-1:0]     irq_status;
	logic [IRQ_W-1:0]     irq_enable;
	logic                 pfail;
	logic [DATA_W-1:0]    rdata_mux;
	logic [NUM_CHAN-1:0]  code_hit;

	wire setup_phase  = PSEL_I & ~PENABLE_I;
	wire access_phase = PSEL_I & PENABLE_I;
	wire wr_access    = access_phase & PWRITE_I;
	wire hit_status   = PADDR_I == STATUS_ADDR;
	wire hit_irq_stat = PADDR_I == IRQ_STATUS_ADDR;
	wire hit_irq_en   = PADDR_I == IRQ_ENABLE_ADDR;
	wire hit_irq_clr  = PADDR_I == IRQ_CLEAR_ADDR;
	wire hit_control  = PADDR_I == CONTROL_ADDR;
	wire hit_any      = (|code_hit) | hit_status | hit_irq_stat | hit_irq_en | hit_irq_clr | hit_control;
	wire wr_irq_en    = wr_access & hit_irq_en;
	wire wr_irq_clr   = wr_access & hit_irq_clr;
	wire force_pfail  = wr_access & hit_control & PWDATA_I[CTRL_FORCE_BIT];

	// zero wait states: every access phase completes at once
	assign PREADY_O  = 1'b1;
	assign PSLVERR_O = access_phase & ~hit_any;

	////////////////////////////////////////////////////////////////////////////////
	// latched channel codes, written by software

	// one register word per channel, low byte used
	genvar gi;
	generate
		for (gi = 0; gi < NUM_CHAN; gi++) begin : g_code
			localparam logic [7:0] OFFS = CODE_BASE_ADDR + CODE_STRIDE * 8'(gi);
			assign code_hit[gi] = PADDR_I == OFFS;
			always_ff @(posedge CLK_I) begin
				if (!RST_N_I) begin
					code[gi] <= CODE_RESET;
				end else if (wr_access & code_hit[gi]) begin
					code[gi] <= PWDATA_I[CHAN_BITS-1:0];
				end
			end
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////////////
	// serial instruction decoder

	state_type            state;
	state_type            next_state;
	logic [INSTR_LEN-1:0] instr;
	logic [2:0]           instr_cnt;
	logic [4:0]           bit_idx;
	logic                 serial_out;
	logic                 serial_oe;

	// bits after the start marker; the first received ends in the msb
	wire [INSTR_LEN-1:0] next_instr = {instr[INSTR_LEN-2:0], sin_bit};
	wire                 instr_last = instr_cnt == 3'(INSTR_LEN - 1);
	wire                 n_rd       = next_instr[INSTR_RD_BIT];                        // RL1
	wire                 n_global   = next_instr[INSTR_G_BIT];
	wire [1:0]           n_sel      = {next_instr[INSTR_HI_BIT], next_instr[INSTR_LO_BIT]};
	wire                 n_read_ok  = n_rd & (~n_global | (n_sel == GLOBAL_SEL));     // RL5

	// readback format, held from the stored instruction
	wire       is_global  = instr[INSTR_G_BIT];
	wire       rise_mode  = instr[INSTR_EDGE_BIT];
	wire       msb_first  = instr[INSTR_ORDER_BIT];
	wire [1:0] chan_sel   = {instr[INSTR_HI_BIT], instr[INSTR_LO_BIT]};
	wire       out_edge   = rise_mode ? sclk_rise : sclk_fall;                         // RL3
	wire [4:0] last_idx   = is_global ? LAST_GLOBAL : LAST_SINGLE;                     // RL13
	wire [1:0] cur_chan   = is_global ? bit_idx[4:3] : chan_sel;                       // RL2 RL11
	wire [2:0] cur_pos    = msb_first ? ~bit_idx[2:0] : bit_idx[2:0];                  // RL4
	wire       cur_bit    = code[cur_chan][cur_pos];                                   // RL13

	// single-cycle events for the bit counter, the readback pin and the sticky status
	wire instr_done_evt = (state == ST_INSTR) & sclk_rise & instr_last;
	wire accept_evt     = instr_done_evt & n_read_ok;
	wire ignore_evt     = instr_done_evt & ~n_read_ok;
	wire drive_evt      = (state == ST_SHIFT) & out_edge;
	wire read_done_evt  = (state == ST_TAIL) & out_edge;

	always_comb begin
		next_state = state;
		if (!cs_active) begin
			next_state = ST_HUNT;
		end else begin
			unique case (state)
				ST_HUNT: begin
					if (sclk_rise & sin_bit) begin                                        // RL12
						next_state = ST_INSTR;
					end
				end
				ST_INSTR: begin
					if (sclk_rise & instr_last) begin
						next_state = n_read_ok ? ST_LEAD : ST_DONE;
					end
				end
				ST_LEAD: begin
					if (out_edge) begin                                                   // RL10
						next_state = ST_SHIFT;
					end
				end
				ST_SHIFT: begin
					if (out_edge & (bit_idx == last_idx)) begin
						next_state = ST_TAIL;
					end
				end
				ST_TAIL: begin
					if (out_edge) begin
						next_state = ST_DONE;
					end
				end
				ST_DONE: begin
					// finished or refused: wait for chip select to rise
					next_state = ST_DONE;
				end
				default: begin
					next_state = ST_HUNT;
				end
			endcase
		end
	end

	always_ff @(posedge CLK_I) begin
		if (!RST_N_I) begin
			state <= ST_HUNT;
		end else begin
			state <= next_state;
		end
	end

	// instruction shifter and counter
	always_ff @(posedge CLK_I) begin
		if (!RST_N_I) begin
			instr     <= '0;
			instr_cnt <= 3'h0;
		end else if (state == ST_HUNT) begin
			instr_cnt <= 3'h0;
		end else if ((state == ST_INSTR) & sclk_rise) begin
			instr     <= next_instr;
			instr_cnt <= instr_cnt + 3'h1;
		end
	end

	// data bit counter, cleared while waiting for the first chosen edge
	always_ff @(posedge CLK_I) begin
		if (!RST_N_I) begin
			bit_idx <= 5'h00;
		end else if (state == ST_LEAD) begin
			bit_idx <= 5'h00;
		end else if (drive_evt) begin
			bit_idx <= bit_idx + 5'h01;
		end
	end

	// readback pin
	// a cut frame wins over a data edge, so no data stands undriven
	always_ff @(posedge CLK_I) begin
		if (!RST_N_I) begin
			serial_out <= 1'b0;
			serial_oe  <= 1'b0;
		end else begin
			serial_oe <= (next_state == ST_LEAD) | (next_state == ST_SHIFT) | (next_state == ST_TAIL);
			if ((next_state == ST_HUNT) | read_done_evt) begin
				serial_out <= 1'b0;
			end else if (drive_evt) begin
				serial_out <= cur_bit;                                                    // RL3 RL4
			end
		end
	end

	assign SERIAL_OUT_O    = serial_out;
	assign SERIAL_OUT_OE_O = serial_oe;

	////////////////////////////////////////////////////////////////////////////////
	// power-fail flag

	// supply loss or the software force sets it; set wins over a clear
	wire pfail_set = lost_rise | force_pfail;
	wire pfail_clr = cs_active;

	always_ff @(posedge CLK_I) begin
		if (!RST_N_I) begin
			pfail <= 1'b1;                                                                // RL6
		end else begin
			pfail <= pfail_set | (pfail & ~pfail_clr);                                    // RL6 RL7
		end
	end

	// open drain: drive low only while the flag is up
	assign INT_N_O    = 1'b0;                                                           // RL8
	assign INT_N_OE_O = pfail;                                                          // RL6 RL7

	////////////////////////////////////////////////////////////////////////////////
	// interrupt status, enable, clear

	logic [IRQ_W-1:0] irq_event;

	always_comb begin
		irq_event                  = '0;
		irq_event[IRQ_INSTR_BIT]   = accept_evt;
		irq_event[IRQ_DONE_BIT]    = read_done_evt;
		irq_event[IRQ_PFCLR_BIT]   = pfail & pfail_clr & ~pfail_set;
		irq_event[IRQ_IGNORED_BIT] = ignore_evt;
	end

	wire [IRQ_W-1:0] irq_clr_mask = wr_irq_clr ? PWDATA_I[IRQ_W-1:0] : '0;

	// a new event wins over a clear in the same cycle
	always_ff @(posedge CLK_I) begin
		if (!RST_N_I) begin
			irq_status <= '0;
			irq_enable <= IRQ_ENABLE_RESET;
		end else begin
			irq_status <= (irq_status & ~irq_clr_mask) | irq_event;
			if (wr_irq_en) begin
				irq_enable <= PWDATA_I[IRQ_W-1:0];
			end
		end
	end

	assign IRQ_O = |(irq_status & irq_enable);

	////////////////////////////////////////////////////////////////////////////////
	// read data

	// busy from start marker until the frame is done or cut
	wire busy = (state != ST_HUNT) & (state != ST_DONE);

	always_comb begin
		rdata_mux = '0;
		for (int i = 0; i < NUM_CHAN; i++) begin
			if (code_hit[i]) begin
				rdata_mux[CHAN_BITS-1:0] = code[i];
			end
		end
		if (hit_status) begin
			rdata_mux[STAT_PFAIL_BIT]                 = pfail;
			rdata_mux[STAT_BUSY_BIT]                  = busy;
			rdata_mux[STAT_CHAN_LSB+1:STAT_CHAN_LSB]  = cur_chan;
			rdata_mux[STAT_INT_PIN_BIT]               = int_sync[1];
		end
		if (hit_irq_stat) begin
			rdata_mux[IRQ_W-1:0] = irq_status;
		end
		if (hit_irq_en) begin
			rdata_mux[IRQ_W-1:0] = irq_enable;
		end
	end

	// loaded in the setup cycle, holds through the access phase
	always_ff @(posedge CLK_I) begin
		if (!RST_N_I) begin
			PRDATA_O <= '0;
		end else if (setup_phase) begin
			PRDATA_O <= PWRITE_I ? '0 : rdata_mux;
		end
	end

endmodule // quad_dac_readback_decoder

`default_nettype wire

// file: hdl/quad_readback_pkg.sv
package quad_readback_pkg;

	////////////////////////////////////////////////////////////////////////////////
	// sizes
	localparam int NUM_CHAN  = 4;
	localparam int CHAN_BITS = 8;
	localparam int ADDR_W    = 8;
	localparam int DATA_W    = 32;
	localparam int IRQ_W     = 4;

	////////////////////////////////////////////////////////////////////////////////
	// register byte offsets
	localparam logic [7:0] CODE_BASE_ADDR  = 8'h00;
	localparam logic [7:0] CODE_STRIDE     = 8'h04;
	localparam logic [7:0] STATUS_ADDR     = 8'h10;
	localparam logic [7:0] IRQ_STATUS_ADDR = 8'h14;
	localparam logic [7:0] IRQ_ENABLE_ADDR = 8'h18;
	localparam logic [7:0] IRQ_CLEAR_ADDR  = 8'h1c;
	localparam logic [7:0] CONTROL_ADDR    = 8'h20;

	////////////////////////////////////////////////////////////////////////////////
	// register fields
	localparam int STAT_PFAIL_BIT   = 0;
	localparam int STAT_BUSY_BIT    = 1;
	localparam int STAT_CHAN_LSB    = 2;
	localparam int STAT_INT_PIN_BIT = 4;
	localparam int IRQ_INSTR_BIT    = 0;
	localparam int IRQ_DONE_BIT     = 1;
	localparam int IRQ_PFCLR_BIT    = 2;
	localparam int IRQ_IGNORED_BIT  = 3;
	localparam int CTRL_FORCE_BIT   = 0;

	localparam logic [7:0]       CODE_RESET       = 8'h00;
	localparam logic [IRQ_W-1:0] IRQ_ENABLE_RESET = 4'h0;

	////////////////////////////////////////////////////////////////////////////////
	// instruction layout after the start marker (first received bit is the msb)
	localparam int         INSTR_LEN      = 6;
	localparam int         INSTR_RD_BIT   = 5;
	localparam int         INSTR_G_BIT    = 4;
	localparam int         INSTR_EDGE_BIT = 3;
	localparam int         INSTR_ORDER_BIT = 2;
	localparam int         INSTR_HI_BIT   = 1;
	localparam int         INSTR_LO_BIT   = 0;
	localparam logic [1:0] GLOBAL_SEL     = 2'h2;
	localparam logic [4:0] LAST_SINGLE    = 5'h07;
	localparam logic [4:0] LAST_GLOBAL    = 5'h1f;

	typedef enum logic [2:0] {
		ST_HUNT  = 3'b000,
		ST_INSTR = 3'b001,
		ST_LEAD  = 3'b010,
		ST_SHIFT = 3'b011,
		ST_TAIL  = 3'b100,
		ST_DONE  = 3'b101
	} state_type;

endpackage

// file: sim/quad_dac_readback_decoder_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module quad_dac_readback_decoder_tb_top
	import quad_readback_pkg::*;
;
	logic              clk = 1'b0;
	logic              rst_n = 1'b0;
	logic              psel = 1'b0;
	logic              pen = 1'b0;
	logic              pwr = 1'b0;
	logic              lost = 1'b0;
	logic [ADDR_W-1:0] paddr = '0;
	logic [DATA_W-1:0] pwdata = '0;
	logic [DATA_W-1:0] rdata;
	logic              rerr;
	logic [7:0]        code [NUM_CHAN] = '{8'ha5, 8'h3c, 8'h81, 8'h5e};
	int                num_errors = 0;
	int                n_tests = 0;
	int                cyc = 0;
	wire [DATA_W-1:0]  prdata;
	wire               prdy, perr, cs_n, sclk, sdi, sdo, sdo_oe, int_o, int_oe, irq;
	wire               int_pin = int_oe ? int_o : 1'b1;
	always #10 clk = ~clk;
	quad_dac_readback_decoder u_quad_dac_readback_decoder (
		.CLK_I(clk), .RST_N_I(rst_n), .PSEL_I(psel), .PENABLE_I(pen), .PWRITE_I(pwr),
		.PADDR_I(paddr), .PWDATA_I(pwdata), .PRDATA_O(prdata), .PREADY_O(prdy),
		.PSLVERR_O(perr), .CS_N_I(cs_n), .SCLK_I(sclk), .SERIAL_IN_I(sdi),
		.SUPPLY_LOST_I(lost), .SERIAL_OUT_O(sdo), .SERIAL_OUT_OE_O(sdo_oe),
		.INT_N_I(int_pin), .INT_N_O(int_o), .INT_N_OE_O(int_oe), .IRQ_O(irq)
	);
	serial_host_model u_serial_host_model (
		.clk_i(clk), .sdo_i(sdo), .sdo_oe_i(sdo_oe), .cs_n_o(cs_n), .sclk_o(sclk), .sdi_o(sdi)
	);
	////////////////////////////////////////////////////////////////////////////////
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		psel <= 1'b1;
		pen <= 1'b0;
		pwr <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		pen <= 1'b1;
		@(posedge clk);
		while (prdy !== 1'b1) @(posedge clk);
		rdata = prdata;
		rerr = perr;
		psel <= 1'b0;
		pen <= 1'b0;
	endtask
	task automatic cmp(input string s, input logic [31:0] e, input logic [31:0] g);
		n_tests++;
		if (g !== e) begin
			num_errors++;
			$display("MISMATCH %s exp %h got %h", s, e, g);
		end
	endtask
	function automatic logic [7:0] ord(input logic msb, input logic [7:0] c);
		return msb ? 8'({<<{c}}) : c;
	endfunction
	task automatic print_verdict();
		if (num_errors == 0 && n_tests > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 80000) begin
			num_errors++;
			print_verdict();
		end
	end
	////////////////////////////////////////////////////////////////////////////////
	initial begin
		repeat (6) @(posedge clk);
		rst_n <= 1'b1;
		repeat (3) @(posedge clk);
		apb(1'b0, STATUS_ADDR, 0);
		cmp("pfail", 1, rdata[STAT_PFAIL_BIT]);
		cmp("int_pin", 0, rdata[STAT_INT_PIN_BIT]);
		apb(1'b0, 8'h40, 0);
		cmp("slverr", 1, rerr);
		cmp("bad_rd", 0, rdata);
		apb(1'b0, IRQ_ENABLE_ADDR, 0);
		cmp("irq_en", IRQ_ENABLE_RESET, rdata);
		for (int c = 0; c < NUM_CHAN; c++) begin
			apb(1'b0, CODE_BASE_ADDR + CODE_STRIDE * 8'(c), 0);
			cmp("code_rst", CODE_RESET, rdata);
			apb(1'b1, CODE_BASE_ADDR + CODE_STRIDE * 8'(c), code[c]);
		end
		apb(1'b1, IRQ_ENABLE_ADDR, 32'h6);
		u_serial_host_model.frame(7'h60, 8);
		cmp("ch1", code[0], u_serial_host_model.got);
		@(negedge clk);
		cmp("int_oe", 0, int_oe);
		cmp("irq", 1, irq);
		apb(1'b1, IRQ_CLEAR_ADDR, 32'hf);
		@(negedge clk);
		cmp("irq", 0, irq);
		for (int m = 0; m < 16; m++) begin
			u_serial_host_model.frame({3'b110, 4'(m)}, 8);
			cmp("single", ord(m[2], code[m[1:0]]), u_serial_host_model.got);
		end
		for (int m = 0; m < 4; m++) begin
			u_serial_host_model.frame({3'b111, 2'(m), 2'b10}, 32);
			cmp("global", {ord(m[0], code[3]), ord(m[0], code[2]), ord(m[0], code[1]),
				ord(m[0], code[0])}, u_serial_host_model.got);
		end
		apb(1'b1, IRQ_CLEAR_ADDR, 32'hf);
		u_serial_host_model.frame(7'h40, 8);
		cmp("wr_mode", 32'h55, u_serial_host_model.got);
		u_serial_host_model.frame(7'h70, 8);
		cmp("bad_glob", 32'h55, u_serial_host_model.got);
		apb(1'b0, IRQ_STATUS_ADDR, 0);
		cmp("ignored", 1, rdata[IRQ_IGNORED_BIT]);
		cmp("done", 0, rdata[IRQ_DONE_BIT]);
		cmp("irq_mask", 0, irq);
		apb(1'b1, IRQ_ENABLE_ADDR, 32'h8);
		@(negedge clk);
		cmp("irq", 1, irq);
		apb(1'b1, IRQ_CLEAR_ADDR, 32'h8);
		@(negedge clk);
		cmp("irq", 0, irq);
		@(posedge clk);
		lost <= 1'b1;
		repeat (4) @(posedge clk);
		lost <= 1'b0;
		repeat (4) @(negedge clk);
		cmp("int_pin", 0, int_pin);
		for (int c = 0; c < NUM_CHAN; c++) begin
			code[c] = ~code[c];
			apb(1'b1, CODE_BASE_ADDR + CODE_STRIDE * 8'(c), code[c]);
		end
		u_serial_host_model.frame(7'h6f, 8);
		cmp("ch4", ord(1'b1, code[3]), u_serial_host_model.got);
		@(negedge clk);
		cmp("int_pin", 1, int_pin);
		apb(1'b0, IRQ_STATUS_ADDR, 0);
		cmp("pf_clr", 1, rdata[IRQ_PFCLR_BIT]);
		apb(1'b1, CONTROL_ADDR, 32'h1);
		repeat (2) @(negedge clk);
		cmp("forced", 1, int_oe);
		print_verdict();
	end
endmodule // quad_dac_readback_decoder_tb_top
`default_nettype wire

// file: sim/quad_readback_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module quad_readback_monitor
	import quad_readback_pkg::*;
(
	input wire logic              CLK_I,           // clock
	input wire logic              RST_N_I,         // reset
	input wire logic              PSEL_I,          // select
	input wire logic              PENABLE_I,       // access
	input wire logic [ADDR_W-1:0] PADDR_I,         // address
	input wire logic [DATA_W-1:0] PRDATA_O,        // read data
	input wire logic              PSLVERR_O,       // error
	input wire logic              CS_N_I,          // select pin
	input wire logic              SCLK_I,          // serial clock
	input wire logic              SUPPLY_LOST_I,   // supply loss
	input wire logic              SERIAL_OUT_O,    // readback
	input wire logic              SERIAL_OUT_OE_O, // readback oe
	input wire logic              INT_N_O,         // int value
	input wire logic              INT_N_OE_O       // int oe
);
	default clocking cb @(posedge CLK_I); endclocking
	default disable iff (!RST_N_I);
	wire acc = PSEL_I & PENABLE_I;
	sequence s_cs_held;
		(!CS_N_I && !SUPPLY_LOST_I && !PSEL_I) [*8];
	endsequence
	sequence s_cs_off;
		CS_N_I [*6];
	endsequence
	sequence s_sclk_calm;
		$stable(SCLK_I) [*4];
	endsequence
	a_err_idle: assert property (!acc |-> !PSLVERR_O)
		else $error("pslverr outside access");
	a_err_unmapped: assert property (acc && PADDR_I > CONTROL_ADDR |-> PSLVERR_O && PRDATA_O == '0)
		else $error("unmapped access not refused");
	a_int_pull_low: assert property (INT_N_OE_O |-> !INT_N_O)
		else $error("int pin driven high");
	a_supply_sets_flag: assert property ($rose(SUPPLY_LOST_I) |-> ##[1:6] INT_N_OE_O)
		else $error("power fail not flagged");
	a_cs_clears_flag: assert property (s_cs_held |-> !INT_N_OE_O)
		else $error("chip select did not clear flag");
	a_deselect_quiet: assert property (s_cs_off |-> !SERIAL_OUT_OE_O)
		else $error("readback driven while deselected");
	a_out_idle_zero: assert property (!SERIAL_OUT_OE_O |-> !SERIAL_OUT_O)
		else $error("readback data without enable");
	a_out_on_edge: assert property (s_sclk_calm |-> $stable(SERIAL_OUT_O))
		else $error("readback changed without clock edge");
endmodule // quad_readback_monitor
bind quad_dac_readback_decoder quad_readback_monitor u_quad_readback_monitor (
	.CLK_I(CLK_I), .RST_N_I(RST_N_I), .PSEL_I(PSEL_I), .PENABLE_I(PENABLE_I),
	.PADDR_I(PADDR_I), .PRDATA_O(PRDATA_O), .PSLVERR_O(PSLVERR_O), .CS_N_I(CS_N_I),
	.SCLK_I(SCLK_I), .SUPPLY_LOST_I(SUPPLY_LOST_I), .SERIAL_OUT_O(SERIAL_OUT_O),
	.SERIAL_OUT_OE_O(SERIAL_OUT_OE_O), .INT_N_O(INT_N_O), .INT_N_OE_O(INT_N_OE_O)
);
`default_nettype wire

// file: sim/serial_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module serial_host_model (
	input  wire logic clk_i,    // system clock
	input  wire logic sdo_i,    // readback data
	input  wire logic sdo_oe_i, // readback enable
	output logic      cs_n_o,   // chip select
	output logic      sclk_o,   // serial clock
	output logic      sdi_o     // serial data
);
	logic [31:0] got;
	initial begin
		cs_n_o = 1'b1;
		sclk_o = 1'b0;
		sdi_o = 1'b0;
		got = '0;
	end
	task automatic half();
		repeat (8) @(posedge clk_i);
	endtask
	// two idle zeros, instruction first bit first, then junk
	task automatic frame(input logic [6:0] ins, input int n);
		got = '0;
		@(posedge clk_i);
		cs_n_o <= 1'b0;
		half();
		for (int k = 0; k < n + 11; k++) begin
			sdi_o <= (k < 2) ? 1'b0 : (k < 9) ? ins[8 - k] : ~sdi_o;
			for (int p = 1; p >= 0; p--) begin
				half();
				sclk_o <= p[0];
				// floating line reads as inverse of last bit
				if (k >= 10 && k < n + 10 && ins[3] != p[0])
					got[k - 10] = sdo_oe_i ? sdo_i : (k == 10 ? 1'b1 : ~got[k - 11]);
			end
		end
		half();
		cs_n_o <= 1'b1;
		half();
	endtask
endmodule // serial_host_model
`default_nettype wire
